// File: inc/isf_map.svh
// Offsets, bit positions, widths and reset values of the status flag block
`default_nettype none
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH

// ****************************************
// Widths
// ****************************************
`define ISF_ADDR_W 4
`define ISF_DATA_W 32
`define ISF_BYTE_W 8
`define ISF_N_EVT 4

// ****************************************
// Register offsets
// ****************************************
`define ISF_OFS_STATUS 4'h0
`define ISF_OFS_RXBUF 4'h4
`define ISF_OFS_TXBUF 4'h8

// ****************************************
// Status bit positions
// ****************************************
`define ISF_BIT_TBF 0
`define ISF_BIT_RBF 1
`define ISF_BIT_RW 2
`define ISF_BIT_START 3
`define ISF_BIT_STOP 4
`define ISF_BIT_WCOL 7

// ****************************************
// Crossing event slots
// ****************************************
`define ISF_EVT_COND 0
`define ISF_EVT_ADDR 1
`define ISF_EVT_RX 2
`define ISF_EVT_DONE 3

// ****************************************
// Reset values
// ****************************************
`define ISF_RST_BIT 1'h0
`define ISF_RST_BYTE 8'h00
`define ISF_RST_WORD 32'h0000_0000
`define ISF_RST_EVT 4'h0

`endif
`default_nettype wire

// File: inc/isf_pkg.sv
// State types of the status flag block
`default_nettype none
`include "isf_map.svh"

package isf_pkg;

	// System-side state
	typedef struct packed {
		logic [`ISF_N_EVT-1:0] s1;
		logic [`ISF_N_EVT-1:0] s2;
		logic [`ISF_N_EVT-1:0] s3;
		logic [`ISF_N_EVT-1:0] seen;
		logic stop_flag;
		logic start_flag;
		logic rw_flag;
		logic rx_buffer_full_flag;
		logic tx_buffer_full_flag;
		logic wcol;
		logic tx_tgl;
		logic [`ISF_BYTE_W-1:0] rx_buf;
		logic [`ISF_BYTE_W-1:0] tx_buf;
		logic [`ISF_DATA_W-1:0] rd_data;
	} isf_sys_t;

	// Link-side state
	typedef struct packed {
		logic [`ISF_N_EVT-1:0] tgl;
		logic cond_stop;
		logic addr_rw;
		logic [`ISF_BYTE_W-1:0] rx_byte;
		logic q1;
		logic q2;
		logic q3;
		logic seen;
		logic tx_pending;
		logic [`ISF_BYTE_W-1:0] tx_data;
	} isf_link_t;

endpackage : isf_pkg
`default_nettype wire

// File: hw/isf_link.sv
// Link-clock side of the status flag block: event toggles and transmit hand-off
`timescale 1ns/1ns
`include "isf_map.svh"
`default_nettype none

module isf_link
	import isf_pkg::*;
(
	// Clock and reset
	input wire logic link_clk,
	input wire logic resetn,
	// Bus engine events, link clock
	input wire logic bus_start_det,
	input wire logic bus_stop_det,
	input wire logic addr_byte_done,
	input wire logic addr_rw_bit,
	input wire logic rx_load,
	input wire logic [`ISF_BYTE_W-1:0] rx_byte,
	input wire logic tx_done,
	// From system side
	input wire logic tx_req_tgl,
	input wire logic [`ISF_BYTE_W-1:0] tx_buf,
	// To system side
	output logic [`ISF_N_EVT-1:0] evt_tgl,
	output logic cond_stop,
	output logic addr_rw,
	output logic [`ISF_BYTE_W-1:0] rx_hold,
	// To bus engine
	output logic tx_pending,
	output logic [`ISF_BYTE_W-1:0] tx_data
);

	logic [1:0] rst_pipe;
	logic link_rstn;
	isf_link_t st;
	isf_link_t next_st;

	// ****************************************
	// Reset release
	// ****************************************
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'h1};
		end
	end
	assign link_rstn = rst_pipe[1];

	// ****************************************
	// Event capture
	// ****************************************
	always_comb begin
		next_st = st;
		// A stop and a start in one cycle cannot occur; stop is checked last
		if (bus_start_det || bus_stop_det) begin
			next_st.cond_stop = bus_stop_det;
			next_st.tgl[`ISF_EVT_COND] = ~st.tgl[`ISF_EVT_COND];
		end
		if (addr_byte_done) begin
			next_st.addr_rw = addr_rw_bit;
			next_st.tgl[`ISF_EVT_ADDR] = ~st.tgl[`ISF_EVT_ADDR];
		end
		if (rx_load) begin
			next_st.rx_byte = rx_byte;
			next_st.tgl[`ISF_EVT_RX] = ~st.tgl[`ISF_EVT_RX];
		end
		// Transmit request from the system side
		next_st.q1 = tx_req_tgl;
		next_st.q2 = st.q1;
		next_st.q3 = st.q2;
		if (tx_done && st.tx_pending) begin
			next_st.tx_pending = 1'h0;
			next_st.tgl[`ISF_EVT_DONE] = ~st.tgl[`ISF_EVT_DONE];
		end
		if (st.q2 == st.q3 && st.q3 != st.seen) begin
			next_st.seen = st.q3;
			next_st.tx_pending = 1'h1;
			next_st.tx_data = tx_buf;
		end
	end

	always_ff @(posedge link_clk or negedge link_rstn) begin
		if (!link_rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign evt_tgl = st.tgl;
	assign cond_stop = st.cond_stop;
	assign addr_rw = st.addr_rw;
	assign rx_hold = st.rx_byte;
	assign tx_pending = st.tx_pending;
	assign tx_data = st.tx_data;

endmodule // isf_link
`default_nettype wire

// File: hw/isf_status.sv
// Low status flags of a two-wire serial bus controller with register port
//
// Functional notes
// - Bit 4 shows stop was last condition
// - Bit 3 shows start was last condition
// - Every start or stop updates both flags
// - Bit 2 gives slave transfer direction
// - Direction loads after address byte received
// - Bit 1 shows received byte waiting
// - Set on receive load, cleared by read
// - Bit 0 shows transmit byte pending
// - Write while busy sets sticky collision flag
`timescale 1ns/1ns
`include "isf_map.svh"
`default_nettype none

module isf_status
	import isf_pkg::*;
(
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic link_clk,

	// Register port, system clock
	input wire logic [`ISF_ADDR_W-1:0] reg_addr,
	input wire logic [`ISF_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`ISF_DATA_W-1:0] reg_rdata,

	// Bus engine events, link clock
	input wire logic bus_start_det,
	input wire logic bus_stop_det,
	input wire logic addr_byte_done,
	input wire logic addr_rw_bit,
	input wire logic rx_load,
	input wire logic [`ISF_BYTE_W-1:0] rx_byte,
	input wire logic tx_done,

	// Transmit hand-off to bus engine, link clock
	output logic tx_pending,
	output logic [`ISF_BYTE_W-1:0] tx_data
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [1:0] rst_pipe;
	logic sys_rstn;
	isf_sys_t st;
	isf_sys_t next_st;
	logic [`ISF_N_EVT-1:0] evt;
	logic [`ISF_N_EVT-1:0] evt_tgl;
	logic lnk_cond_stop;
	logic lnk_addr_rw;
	logic [`ISF_BYTE_W-1:0] lnk_rx_hold;
	logic wr_status;
	logic wr_txbuf;
	logic rd_rxbuf;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic isf_hit(
		input logic [`ISF_ADDR_W-1:0] addr,
		input logic [`ISF_ADDR_W-1:0] ofs
	);
		isf_hit = (addr == ofs);
	endfunction

	// Status word as software sees it
	function automatic logic [`ISF_DATA_W-1:0] isf_status_word(
		input isf_sys_t s
	);
		logic [`ISF_DATA_W-1:0] w;
		w = `ISF_RST_WORD;
		w[`ISF_BIT_STOP] = s.stop_flag;
		w[`ISF_BIT_START] = s.start_flag;
		w[`ISF_BIT_RW] = s.rw_flag;
		w[`ISF_BIT_RBF] = s.rx_buffer_full_flag;
		w[`ISF_BIT_TBF] = s.tx_buffer_full_flag;
		w[`ISF_BIT_WCOL] = s.wcol;
		isf_status_word = w;
	endfunction

	// ****************************************
	// Reset release
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'h1};
		end
	end
	assign sys_rstn = rst_pipe[1];

	// ****************************************
	// Link-side logic
	// ****************************************
	isf_link u_link (
		.link_clk(link_clk),
		.resetn(resetn),
		.bus_start_det(bus_start_det),
		.bus_stop_det(bus_stop_det),
		.addr_byte_done(addr_byte_done),
		.addr_rw_bit(addr_rw_bit),
		.rx_load(rx_load),
		.rx_byte(rx_byte),
		.tx_done(tx_done),
		.tx_req_tgl(st.tx_tgl),
		.tx_buf(st.tx_buf),
		.evt_tgl(evt_tgl),
		.cond_stop(lnk_cond_stop),
		.addr_rw(lnk_addr_rw),
		.rx_hold(lnk_rx_hold),
		.tx_pending(tx_pending),
		.tx_data(tx_data)
	);

	// ****************************************
	// Strobe qualification
	// ****************************************
	assign wr_status = reg_wr && isf_hit(reg_addr, `ISF_OFS_STATUS);
	assign wr_txbuf = reg_wr && isf_hit(reg_addr, `ISF_OFS_TXBUF);
	assign rd_rxbuf = reg_rd && isf_hit(reg_addr, `ISF_OFS_RXBUF);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_st = st;
		evt = `ISF_RST_EVT;

		// Toggle crossing: three stages, accepted once stages two and three agree
		next_st.s1 = evt_tgl;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < `ISF_N_EVT; i++) begin
			if (st.s2[i] == st.s3[i] && st.s3[i] != st.seen[i]) begin
				next_st.seen[i] = st.s3[i];
				evt[i] = 1'h1;
			end
		end

		// Latest bus condition; the held kind is stable once its toggle lands
		if (evt[`ISF_EVT_COND]) begin
			next_st.stop_flag = lnk_cond_stop;
			next_st.start_flag = ~lnk_cond_stop;
		end

		// Slave direction from the address byte
		if (evt[`ISF_EVT_ADDR]) begin
			next_st.rw_flag = lnk_addr_rw;
		end

		// Receive buffer: a load in the cycle of a read keeps the flag set
		if (rd_rxbuf) begin
			next_st.rx_buffer_full_flag = 1'h0;
		end
		if (evt[`ISF_EVT_RX]) begin
			next_st.rx_buf = lnk_rx_hold;
			next_st.rx_buffer_full_flag = 1'h1;
		end

		// Transmit buffer: pending from write until the engine reports done
		if (evt[`ISF_EVT_DONE]) begin
			next_st.tx_buffer_full_flag = 1'h0;
		end

		// Collision flag: software clears by writing zero, a new hit wins
		if (wr_status && !reg_wdata[`ISF_BIT_WCOL]) begin
			next_st.wcol = 1'h0;
		end
		if (wr_txbuf) begin
			if (st.tx_buffer_full_flag) begin
				// Busy: data discarded, flag stays until cleared
				next_st.wcol = 1'h1;
			end else begin
				next_st.tx_buf = reg_wdata[`ISF_BYTE_W-1:0];
				next_st.tx_buffer_full_flag = 1'h1;
				next_st.tx_tgl = ~st.tx_tgl;
			end
		end

		// Read data stand for one cycle only, zero otherwise
		next_st.rd_data = `ISF_RST_WORD;
		if (reg_rd) begin
			unique case (reg_addr)
				`ISF_OFS_STATUS: begin
					// Hardware-owned bits are never loaded from writes
					next_st.rd_data = isf_status_word(st);
				end
				`ISF_OFS_RXBUF: begin
					next_st.rd_data[`ISF_BYTE_W-1:0] = st.rx_buf;
				end
				`ISF_OFS_TXBUF: begin
					next_st.rd_data[`ISF_BYTE_W-1:0] = st.tx_buf;
				end
				default: begin
					next_st.rd_data = `ISF_RST_WORD;
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge sys_clk or negedge sys_rstn) begin
		if (!sys_rstn) begin
			st.s1 <= `ISF_RST_EVT;
			st.s2 <= `ISF_RST_EVT;
			st.s3 <= `ISF_RST_EVT;
			st.seen <= `ISF_RST_EVT;
			st.stop_flag <= `ISF_RST_BIT;
			st.start_flag <= `ISF_RST_BIT;
			st.rw_flag <= `ISF_RST_BIT;
			st.rx_buffer_full_flag <= `ISF_RST_BIT;
			st.tx_buffer_full_flag <= `ISF_RST_BIT;
			st.wcol <= `ISF_RST_BIT;
			st.tx_tgl <= `ISF_RST_BIT;
			st.rx_buf <= `ISF_RST_BYTE;
			st.tx_buf <= `ISF_RST_BYTE;
			st.rd_data <= `ISF_RST_WORD;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = st.rd_data;

endmodule // isf_status
`default_nettype wire

// File: bench/isf_status_properties.sv
// Port checker for the status flag block
`timescale 1ns/1ns
`include "isf_map.svh"
`default_nettype none

module isf_status_chk (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic link_clk,
	input wire logic resetn,
	// Register port
	input wire logic [`ISF_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`ISF_DATA_W-1:0] reg_rdata,
	// Transmit hand-off
	input wire logic tx_done,
	input wire logic tx_pending,
	input wire logic [`ISF_BYTE_W-1:0] tx_data
);
	logic st_rd;
	assign st_rd = reg_rd && reg_addr == `ISF_OFS_STATUS;

	rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside answer cycle");
	upper_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$past(reg_rd) |-> reg_rdata[31:8] == 24'h0) else $error("upper read bits set");
	cond_excl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$past(st_rd) |-> !(reg_rdata[`ISF_BIT_STOP] && reg_rdata[`ISF_BIT_START]))
		else $error("start and stop flags both set");
	st_gap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$past(st_rd) |-> reg_rdata[6:5] == 2'h0) else $error("unused status bits set");
	tbf_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		reg_wr && reg_addr == `ISF_OFS_TXBUF ##2 st_rd |=> reg_rdata[`ISF_BIT_TBF])
		else $error("transmit full flag not set after write");
	tx_hold_a: assert property (@(posedge link_clk) disable iff (!resetn)
		tx_pending && !tx_done |=> tx_pending) else $error("pending dropped early");
	tx_drop_a: assert property (@(posedge link_clk) disable iff (!resetn)
		tx_pending && tx_done |=> !tx_pending) else $error("pending kept after done");
	tx_data_a: assert property (@(posedge link_clk) disable iff (!resetn)
		tx_pending && !tx_done |=> $stable(tx_data)) else $error("transmit byte changed");

	cover property (@(posedge link_clk) tx_pending && tx_done);
	cover property (@(posedge sys_clk) $past(st_rd) && reg_rdata[`ISF_BIT_START]);
	cover property (@(posedge sys_clk) $past(st_rd) && reg_rdata[`ISF_BIT_WCOL]);
endmodule // isf_status_chk
`default_nettype wire

// File: bench/isf_engine_model.sv
// Behavioural bus engine on the link clock side
`timescale 1ns/1ns
`include "isf_map.svh"
`default_nettype none

module isf_engine_model (
	// Clock and reset
	input wire logic link_clk,
	input wire logic resetn,
	// Transmit hand-off
	input wire logic tx_pending,
	input wire logic [`ISF_BYTE_W-1:0] tx_data,
	// Engine events
	output logic [3:0] evt,
	output logic addr_rw_bit,
	output logic [`ISF_BYTE_W-1:0] rx_byte,
	output logic tx_done
);
	int slow_n = 0;
	int cnt = 0;
	logic [`ISF_BYTE_W-1:0] last_tx = 8'h00;

	initial begin
		evt = 4'h0;
		addr_rw_bit = 1'b0;
		rx_byte = 8'h00;
	end

	// One pulse, then spacing; qualifiers turn over once their hold is done
	task automatic pulse(input int k, input logic [7:0] v);
		@(posedge link_clk);
		evt <= 4'h1 << k;
		rx_byte <= v;
		addr_rw_bit <= v[0];
		@(posedge link_clk);
		evt <= 4'h0;
		rx_byte <= ~v;
		addr_rw_bit <= ~v[0];
		repeat (2) @(posedge link_clk);
	endtask

	// Finishes a pending byte after slow_n link cycles
	always @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			tx_done <= 1'b0;
			cnt <= 0;
		end else begin
			tx_done <= 1'b0;
			if (tx_pending && !tx_done) begin
				if (cnt >= slow_n) begin
					tx_done <= 1'b1;
					last_tx <= tx_data;
					cnt <= 0;
				end else begin
					cnt <= cnt + 1;
				end
			end
		end
	end
endmodule // isf_engine_model
`default_nettype wire

// File: bench/test_isf_status.sv
// Testbench of the status flag block
`timescale 1ns/1ns
`include "isf_map.svh"
`default_nettype none

module test_isf_status;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [3:0] evt;
	logic rw_bit, tx_done, tx_pending;
	logic [7:0] rx_byte, tx_data, exp_st, got;
	int err_count = 0;
	int n_checks = 0;

	isf_status u_isf_status (.sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bus_start_det(evt[0]), .bus_stop_det(evt[1]),
		.addr_byte_done(evt[2]), .addr_rw_bit(rw_bit), .rx_load(evt[3]),
		.rx_byte(rx_byte), .tx_done(tx_done), .tx_pending(tx_pending), .tx_data(tx_data));
	isf_engine_model u_isf_engine_model (.link_clk(link_clk), .resetn(resetn),
		.tx_pending(tx_pending), .tx_data(tx_data), .evt(evt), .addr_rw_bit(rw_bit),
		.rx_byte(rx_byte), .tx_done(tx_done));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		forever begin
			#62 link_clk = 1'b1;
			#63 link_clk = 1'b0;
		end
	end

	// ****************************************
	// Bus tasks and comparison
	// ****************************************
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
			err_count++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata[7:0];
	endtask
	task automatic ev(input int k, input logic [7:0] v, input logic [7:0] e);
		u_isf_engine_model.pulse(k, v);
		repeat (10) @(posedge sys_clk);
		exp_st = e;
		rd(`ISF_OFS_STATUS, got);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		exp_st = 8'h00;
		rd(`ISF_OFS_STATUS, got); chk(got, exp_st);
		wr(`ISF_OFS_STATUS, 32'h0000_001F);
		rd(`ISF_OFS_STATUS, got); chk(got, exp_st);
		rd(4'hC, got); chk(got, 8'h00);
	endtask
	task automatic t_cond();
		ev(0, 8'h00, 8'h08); chk(got, exp_st);
		ev(1, 8'h00, 8'h10); chk(got, exp_st);
		ev(0, 8'h00, 8'h08); chk(got, exp_st);
	endtask
	task automatic t_dir();
		ev(2, 8'h01, 8'h0C); chk(got, exp_st);
		ev(2, 8'h00, 8'h08); chk(got, exp_st);
	endtask
	task automatic t_rx();
		ev(3, 8'hA5, 8'h0A); chk(got, exp_st);
		rd(`ISF_OFS_RXBUF, got); chk(got, 8'hA5);
		rd(`ISF_OFS_STATUS, got); chk(got, 8'h08);
	endtask
	task automatic t_tx(input int slow, input logic [7:0] b);
		int i;
		u_isf_engine_model.slow_n = slow;
		wr(`ISF_OFS_TXBUF, {24'h0, b});
		rd(`ISF_OFS_STATUS, got); chk(got, 8'h09);
		wr(`ISF_OFS_TXBUF, 32'h0000_0055);
		rd(`ISF_OFS_STATUS, got); chk(got[7], 1'b1);
		for (i = 0; i < 300 && got[0] !== 1'b0; i++) rd(`ISF_OFS_STATUS, got);
		if (got[0] !== 1'b0) begin
			$display("CHECK FAILED at %0t: transmit never finished", $time);
			err_count++;
		end else begin
			chk(got, 8'h88);
			chk(u_isf_engine_model.last_tx, b);
			rd(`ISF_OFS_TXBUF, got); chk(got, b);
			wr(`ISF_OFS_STATUS, 32'h0);
			rd(`ISF_OFS_STATUS, got); chk(got, 8'h08);
		end
	endtask
	task automatic t_rst_mid();
		ev(3, 8'h5A, 8'h0A); chk(got, exp_st);
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (13) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(`ISF_OFS_STATUS, got); chk(got, 8'h00);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_cond();
		t_dir();
		t_rx();
		t_tx(0, 8'h3C);
		t_tx(6, 8'hC3);
		t_rst_mid();
		print_verdict();
	end
endmodule // test_isf_status

bind isf_status isf_status_chk u_isf_status_chk (.sys_clk(sys_clk), .link_clk(link_clk),
	.resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tx_done(tx_done), .tx_pending(tx_pending), .tx_data(tx_data));
`default_nettype wire
